// >>> shared/isd_pkg.sv
// Shared constants and types for the file-op decoder slice
package isd_pkg;
	// Datapath widths
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned PC_W = 16;
	localparam int unsigned REG_AW = 8;
	// Opcode prefixes
	localparam logic [5:0] PFX_INC_SKZ = 6'h0f;
	localparam logic [5:0] PFX_INC_SKNZ = 6'h12;
	localparam logic [5:0] PFX_OR_FILE = 6'h04;
	localparam logic [5:0] PFX_MOVE_FILE_VALUE = 6'h14;
	localparam logic [7:0] PFX_OR_LIT = 8'h09;
	localparam logic [9:0] PFX_LDPTR = 10'h3b8;
	localparam logic [3:0] PFX_MOVE_FILE_TO_FILE = 4'hc;
	localparam logic [3:0] PFX_SECOND = 4'hf;
	localparam logic [7:0] PFX_JUMP_FAR = 8'hef;
	localparam logic [6:0] PFX_CALL_FAR = 7'h76;
	// Address forming
	localparam logic [7:0] ACC_SPLIT = 8'h80;
	localparam logic [7:0] IDX_MAX = 8'h5f;
	localparam logic [3:0] ACC_HI_BANK = 4'hf;
	localparam logic [3:0] ACC_LO_BANK = 4'h0;
	localparam logic [1:0] IDX_PTR = 2'h2;
	localparam logic [1:0] PTR_LAST = 2'h2;
	localparam logic [1:0] FLUSH_ONE = 2'h1;
	// Register offsets
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] REG_BANK = 8'h04;
	localparam logic [REG_AW-1:0] REG_ACC = 8'h08;
	localparam logic [REG_AW-1:0] REG_FLAGS = 8'h0c;
	localparam logic [REG_AW-1:0] REG_PTR0 = 8'h10;
	localparam logic [REG_AW-1:0] REG_PTR1 = 8'h14;
	localparam logic [REG_AW-1:0] REG_PTR2 = 8'h18;
	localparam logic [REG_AW-1:0] REG_PC = 8'h1c;
	// Field positions
	localparam int unsigned CTRL_EXT_BIT = 0;
	localparam int unsigned FLAG_Z_BIT = 0;
	localparam int unsigned FLAG_N_BIT = 1;
	// Reset values
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [11:0] RST_PTR = 12'h000;
	localparam logic [15:0] RST_PC = 16'h0000;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Decoded operation
	typedef enum logic [3:0] {
		OP_NOP, OP_INC_SKZ, OP_INC_SKNZ, OP_OR_LIT, OP_OR_FILE,
		OP_LDPTR_HI, OP_MOVE_FILE_VALUE, OP_MOVE_FILE_TO_FILE_SRC, OP_SECOND, OP_OTHER2
	} isd_op_t;
	// Four phases of one instruction cycle
	typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} isd_phase_t;
	// Pending second word
	typedef enum logic [1:0] {SEC_NONE, SEC_LDPTR, SEC_MOVE_FILE_TO_FILE} isd_sec_t;
endpackage

// >>> core/isd_decode.sv
// Opcode classifier for one program word
`timescale 1ns/1ps
`default_nettype none
module isd_decode import isd_pkg::*; (
	// Word in
	input wire logic [15:0] word,
	// Classified fields
	output isd_op_t op,
	output logic two_word
);
	// Classify by prefix
	always_comb begin
		op = OP_NOP;
		if (word[15:10] == PFX_INC_SKZ) begin
			op = OP_INC_SKZ;
		end else if (word[15:10] == PFX_INC_SKNZ) begin
			op = OP_INC_SKNZ;
		end else if (word[15:8] == PFX_OR_LIT) begin
			op = OP_OR_LIT;
		end else if (word[15:10] == PFX_OR_FILE) begin
			op = OP_OR_FILE;
		end else if (word[15:10] == PFX_MOVE_FILE_VALUE) begin
			op = OP_MOVE_FILE_VALUE;
		end else if (word[15:6] == PFX_LDPTR && word[5:4] <= PTR_LAST) begin
			op = OP_LDPTR_HI;
		end else if (word[15:12] == PFX_MOVE_FILE_TO_FILE) begin
			op = OP_MOVE_FILE_TO_FILE_SRC;
		end else if (word[15:12] == PFX_SECOND) begin
			op = OP_SECOND;
		end else if (word[15:8] == PFX_JUMP_FAR || word[15:9] == PFX_CALL_FAR) begin
			op = OP_OTHER2;
		end
	end
	// First word of a two-word instruction
	assign two_word = (op == OP_LDPTR_HI) || (op == OP_MOVE_FILE_TO_FILE_SRC) || (op == OP_OTHER2);
endmodule // isd_decode
`default_nettype wire

// >>> core/isd_axil.sv
// AXI4-Lite slave front end for the control registers
`timescale 1ns/1ps
`default_nettype none
module isd_axil import isd_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read channels
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Register side
	output logic reg_wr,
	output logic [7:0] reg_wr_addr,
	output logic [31:0] reg_wr_data,
	output logic [3:0] reg_wr_strb,
	input wire logic reg_wr_ok,
	output logic [7:0] reg_rd_addr,
	input wire logic [31:0] reg_rd_data,
	input wire logic reg_rd_ok
);
	// Slave state
	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
	} isd_axil_st_t;
	isd_axil_st_t s_q, s_d;
	// Ready while the holding slot is free
	assign awready = !s_q.aw_full;
	assign wready = !s_q.w_full;
	assign arready = !s_q.r_valid;
	assign bvalid = s_q.b_valid;
	assign bresp = s_q.b_resp;
	assign rvalid = s_q.r_valid;
	assign rdata = s_q.r_data;
	assign rresp = s_q.r_resp;
	assign reg_wr_addr = s_q.aw_addr;
	assign reg_wr_data = s_q.w_data;
	assign reg_wr_strb = s_q.w_strb;
	assign reg_rd_addr = araddr;
	// Commit a write once address and data are both held
	assign reg_wr = s_q.aw_full && s_q.w_full && !s_q.b_valid;
	// Next state
	always_comb begin
		s_d = s_q;
		if (s_q.b_valid && bready) begin
			s_d.b_valid = 1'b0;
		end
		if (reg_wr) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.b_valid = 1'b1;
			s_d.b_resp = reg_wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (awvalid && !s_q.aw_full) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && !s_q.w_full) begin
			s_d.w_full = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (s_q.r_valid && rready) begin
			s_d.r_valid = 1'b0;
		end
		if (arvalid && !s_q.r_valid) begin
			s_d.r_valid = 1'b1;
			s_d.r_data = reg_rd_data;
			s_d.r_resp = reg_rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // isd_axil
`default_nettype wire

// >>> core/isd_core.sv
// File-op decoder and execute slice with its register port
// How it works
// [RQ1] Skip-if-zero increment writes file plus one
// [RQ2] Destination bit picks accumulator or file
// [RQ3] Zero result flushes the prefetched next word
// [RQ4] Skip-if-nonzero flushes when result nonzero
// [RQ5] Skipped two-word instruction flushes both words
// [RQ6] Increment-skip forms leave flags untouched
// [RQ7] Bank bit picks access bank or bank register
// [RQ8] Extended mode indexes low access addresses
// [RQ9] OR literal into accumulator, set N and Z
// [RQ10] OR accumulator with file, set N and Z
// [RQ11] Two-word pointer load, high then low
// [RQ12] Move file to accumulator or itself, flags
// [RQ13] File field reaches all 256 bank bytes
// [RQ14] File-to-file move from prefix words
// [RQ15] File-to-file move spans full 4K space
// [RQ16] Four phases: decode, read, process, write
// [RQ17] Flushed slot has no effect but advances
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module isd_core import isd_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Instruction fetch
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	output logic instr_ready,
	output logic [15:0] fetch_pc,
	// Data memory
	output logic [11:0] dm_addr,
	output logic dm_rd_en,
	input wire logic [7:0] dm_rdata,
	output logic dm_wr_en,
	output logic [7:0] dm_wdata,
	// Register bus write
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Register bus read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	// Whole core state
	typedef struct packed {
		isd_phase_t phase;
		logic [15:0] pc;
		logic [15:0] word;
		isd_sec_t sec;
		logic [1:0] flush;
		logic slot_flush;
		logic [1:0] ptr_sel;
		logic [7:0] hold;
		logic [11:0] addr;
		logic [7:0] acc;
		logic flag_z;
		logic flag_n;
		logic [3:0] bank;
		logic ext_en;
		logic [2:0][11:0] ptr;
		logic [11:0] dm_addr;
		logic dm_rd;
		logic dm_wr;
		logic [7:0] dm_wdata;
	} isd_core_st_t;
	isd_core_st_t s_q, s_d;

	// Bus side wires
	logic reg_wr;
	logic [7:0] reg_wr_addr;
	logic [31:0] reg_wr_data;
	logic [3:0] reg_wr_strb;
	logic reg_wr_ok;
	logic [7:0] reg_rd_addr;
	logic [31:0] reg_rd_data;
	logic reg_rd_ok;
	// Decoder wires
	logic [15:0] dec_word;
	isd_op_t op;
	logic two_word;
	// Working values
	logic [7:0] f;
	logic [7:0] sum;
	logic [31:0] wr_val;
	logic exec;

	// Known register offset
	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == REG_CTRL) || (a == REG_BANK) || (a == REG_ACC) || (a == REG_FLAGS) ||
			(a == REG_PTR0) || (a == REG_PTR1) || (a == REG_PTR2) || (a == REG_PC);
	endfunction

	// Data address of a banked file operand
	function automatic logic [11:0] form_addr(input logic a, input logic [7:0] fa,
		input logic [3:0] bk, input logic ext, input logic [11:0] base);
		if (a) begin
			form_addr = {bk, fa}; // RQ7 RQ13
		end else if (ext && fa <= IDX_MAX) begin
			form_addr = base + {4'h0, fa}; // RQ8
		end else if (fa < ACC_SPLIT) begin
			form_addr = {ACC_LO_BANK, fa}; // RQ7
		end else begin
			form_addr = {ACC_HI_BANK, fa}; // RQ7
		end
	endfunction

	// Merge a bus write under its byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// Register bus front end
	isd_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.reg_wr(reg_wr),
		.reg_wr_addr(reg_wr_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr_strb(reg_wr_strb),
		.reg_wr_ok(reg_wr_ok),
		.reg_rd_addr(reg_rd_addr),
		.reg_rd_data(reg_rd_data),
		.reg_rd_ok(reg_rd_ok)
	);

	// Decode the arriving word in the first phase, the held one after
	assign dec_word = (s_q.phase == PH_DECODE) ? instr_word : s_q.word;
	isd_decode u_dec (
		.word(dec_word),
		.op(op),
		.two_word(two_word)
	);

	// Outputs straight from state
	assign instr_ready = (s_q.phase == PH_DECODE);
	assign fetch_pc = s_q.pc;
	assign dm_addr = s_q.dm_addr;
	assign dm_rd_en = s_q.dm_rd;
	assign dm_wr_en = s_q.dm_wr;
	assign dm_wdata = s_q.dm_wdata;
	assign reg_wr_ok = reg_known(reg_wr_addr);
	assign reg_rd_ok = reg_known(reg_rd_addr);

	// Register read mux
	always_comb begin
		reg_rd_data = 32'h0000_0000;
		unique case (reg_rd_addr)
			REG_CTRL: reg_rd_data[CTRL_EXT_BIT] = s_q.ext_en;
			REG_BANK: reg_rd_data[3:0] = s_q.bank;
			REG_ACC: reg_rd_data[7:0] = s_q.acc;
			REG_FLAGS: begin
				reg_rd_data[FLAG_Z_BIT] = s_q.flag_z;
				reg_rd_data[FLAG_N_BIT] = s_q.flag_n;
			end
			REG_PTR0: reg_rd_data[11:0] = s_q.ptr[0];
			REG_PTR1: reg_rd_data[11:0] = s_q.ptr[1];
			REG_PTR2: reg_rd_data[11:0] = s_q.ptr[2];
			REG_PC: reg_rd_data[15:0] = s_q.pc;
			default: reg_rd_data = 32'h0000_0000;
		endcase
	end

	// Operand fields of the held word
	assign f = s_q.word[7:0];
	assign sum = dm_rdata + 8'h01;
	// Slot really executes: not flushed, not an operand word
	assign exec = !s_q.slot_flush && (s_q.sec == SEC_NONE);

	// Next state: bus writes first, core commits after and wins
	always_comb begin
		s_d = s_q;
		s_d.dm_rd = 1'b0;
		s_d.dm_wr = 1'b0;
		wr_val = 32'h0000_0000;
		// Software register writes
		if (reg_wr) begin
			unique case (reg_wr_addr)
				REG_CTRL: begin
					wr_val = merge({31'h0, s_q.ext_en}, reg_wr_data, reg_wr_strb);
					s_d.ext_en = wr_val[CTRL_EXT_BIT];
				end
				REG_BANK: begin
					wr_val = merge({28'h0, s_q.bank}, reg_wr_data, reg_wr_strb);
					s_d.bank = wr_val[3:0];
				end
				REG_ACC: begin
					wr_val = merge({24'h0, s_q.acc}, reg_wr_data, reg_wr_strb);
					s_d.acc = wr_val[7:0];
				end
				REG_FLAGS: begin
					wr_val = merge({30'h0, s_q.flag_n, s_q.flag_z}, reg_wr_data, reg_wr_strb);
					s_d.flag_z = wr_val[FLAG_Z_BIT];
					s_d.flag_n = wr_val[FLAG_N_BIT];
				end
				REG_PTR0: begin
					wr_val = merge({20'h0, s_q.ptr[0]}, reg_wr_data, reg_wr_strb);
					s_d.ptr[0] = wr_val[11:0];
				end
				REG_PTR1: begin
					wr_val = merge({20'h0, s_q.ptr[1]}, reg_wr_data, reg_wr_strb);
					s_d.ptr[1] = wr_val[11:0];
				end
				REG_PTR2: begin
					wr_val = merge({20'h0, s_q.ptr[2]}, reg_wr_data, reg_wr_strb);
					s_d.ptr[2] = wr_val[11:0];
				end
				default: begin
					// Program counter and unmapped offsets ignore writes
				end
			endcase
		end
		// Instruction cycle sequencer
		unique case (s_q.phase)
			PH_DECODE: begin
				// Take a word; stall here while none is offered
				if (instr_valid) begin
					s_d.word = instr_word;
					s_d.pc = s_q.pc + 16'h0001; // RQ17
					s_d.phase = PH_READ; // RQ16
					s_d.slot_flush = 1'b0;
					if (s_q.flush != 2'h0) begin
						s_d.slot_flush = 1'b1; // RQ17
						s_d.sec = SEC_NONE;
						// A skipped two-word head keeps one more flush pending
						if (!(s_q.flush == FLUSH_ONE && two_word)) begin
							s_d.flush = s_q.flush - 2'h1; // RQ5
						end
					end
				end
			end
			PH_READ: begin
				// Form the address and start the file read
				s_d.phase = PH_PROC; // RQ16
				if (exec) begin
					s_d.addr = form_addr(s_q.word[8], f, s_q.bank, s_q.ext_en, s_q.ptr[IDX_PTR]);
					unique case (op)
						OP_INC_SKZ, OP_INC_SKNZ, OP_OR_FILE, OP_MOVE_FILE_VALUE: begin
							s_d.dm_addr = form_addr(s_q.word[8], f, s_q.bank, s_q.ext_en, s_q.ptr[IDX_PTR]);
							s_d.dm_rd = 1'b1;
						end
						OP_MOVE_FILE_TO_FILE_SRC: begin
							s_d.dm_addr = s_q.word[11:0]; // RQ14 RQ15
							s_d.dm_rd = 1'b1;
						end
						default: begin
							// Literal and pointer forms read no file
						end
					endcase
				end
			end
			PH_PROC: begin
				// Process data; results show during the write phase
				s_d.phase = PH_WRITE; // RQ16
				if (!s_q.slot_flush && s_q.sec == SEC_LDPTR) begin
					s_d.ptr[s_q.ptr_sel][7:0] = f; // RQ11
					s_d.sec = SEC_NONE;
				end else if (!s_q.slot_flush && s_q.sec == SEC_MOVE_FILE_TO_FILE) begin
					s_d.dm_addr = s_q.word[11:0]; // RQ14 RQ15
					s_d.dm_wdata = s_q.hold;
					s_d.dm_wr = 1'b1;
					s_d.sec = SEC_NONE;
				end else if (exec) begin
					unique case (op)
						OP_INC_SKZ, OP_INC_SKNZ: begin
							// Flags stay as they are
							if (s_q.word[9]) begin
								s_d.dm_addr = s_q.addr; // RQ2
								s_d.dm_wdata = sum; // RQ1
								s_d.dm_wr = 1'b1;
							end else begin
								s_d.acc = sum; // RQ2 RQ6
							end
							if ((op == OP_INC_SKZ) == (sum == 8'h00)) begin
								s_d.flush = FLUSH_ONE; // RQ3 RQ4
							end
						end
						OP_OR_LIT: begin
							s_d.acc = s_q.acc | f; // RQ9
							s_d.flag_z = ((s_q.acc | f) == 8'h00);
							s_d.flag_n = s_q.acc[7] | f[7];
						end
						OP_OR_FILE, OP_MOVE_FILE_VALUE: begin
							wr_val[7:0] = (op == OP_MOVE_FILE_VALUE) ? dm_rdata : (s_q.acc | dm_rdata); // RQ10 RQ12
							if (s_q.word[9]) begin
								s_d.dm_addr = s_q.addr; // RQ2
								s_d.dm_wdata = wr_val[7:0];
								s_d.dm_wr = 1'b1;
							end else begin
								s_d.acc = wr_val[7:0]; // RQ2
							end
							s_d.flag_z = (wr_val[7:0] == 8'h00);
							s_d.flag_n = wr_val[7];
						end
						OP_LDPTR_HI: begin
							s_d.ptr[s_q.word[5:4]][11:8] = s_q.word[3:0]; // RQ11
							s_d.ptr_sel = s_q.word[5:4];
							s_d.sec = SEC_LDPTR;
						end
						OP_MOVE_FILE_TO_FILE_SRC: begin
							s_d.hold = dm_rdata; // RQ14
							s_d.sec = SEC_MOVE_FILE_TO_FILE;
						end
						default: begin
							// Stray second words and other opcodes do nothing here
						end
					endcase
				end
			end
			PH_WRITE: begin
				// Last phase; strobes raised in process are visible now
				s_d.phase = PH_DECODE; // RQ16
			end
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.phase <= PH_DECODE;
			s_q.sec <= SEC_NONE;
			s_q.pc <= RST_PC;
			s_q.acc <= RST_ACC;
			s_q.bank <= RST_BANK;
			s_q.ptr <= {RST_PTR, RST_PTR, RST_PTR};
		end else begin
			s_q <= s_d;
		end
	end
endmodule // isd_core
`default_nettype wire

// >>> dv/isd_checker.sv
// Port-level assertions for the file-op decoder slice
`timescale 1ns/1ps
`default_nettype none
module isd_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Fetch and data memory
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [15:0] fetch_pc,
	input wire logic dm_rd_en,
	input wire logic dm_wr_en,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A program word is taken at this edge
	wire logic take = instr_ready && instr_valid;
	// Each slot, flushed or not, runs decode then three busy phases
	AST_FETCH_PHASES: assert property (take |=> !instr_ready [*3] ##1 instr_ready)
		else $error("fetch slot did not last four cycles");
	// Count of words steps once per word taken, flushed ones too
	AST_PC_STEP: assert property (take |=> fetch_pc == $past(fetch_pc) + 16'h0001)
		else $error("fetch count did not step on a take");
	AST_PC_HOLD: assert property (!take |=> $stable(fetch_pc))
		else $error("fetch count moved without a take");
	// Reads only happen inside the busy phases
	AST_RD_PHASE: assert property (dm_rd_en |-> !instr_ready && !dm_wr_en)
		else $error("data read outside the read phase");
	AST_RD_PULSE: assert property (dm_rd_en |=> !dm_rd_en)
		else $error("read strobe longer than one cycle");
	// Write is the last phase, decode follows at once
	AST_WR_LAST: assert property (dm_wr_en |=> instr_ready && !dm_wr_en)
		else $error("write strobe not in the last phase");
	// Register bus answers
	AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read answer missing");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped early");
	AST_AR_BLOCK: assert property (rvalid |-> !arready)
		else $error("read address taken while answer pending");
	AST_B_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	// Main scenarios reached
	COV_TAKE: cover property (take ##4 take);
	COV_WRITE: cover property (dm_rd_en ##1 dm_wr_en);
	COV_BUS: cover property (bvalid && bready ##1 arvalid && arready);
endmodule // isd_checker
bind isd_core isd_checker isd_checker_i (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
	.instr_ready(instr_ready), .fetch_pc(fetch_pc), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata));
`default_nettype wire

// >>> dv/isd_mem_model.sv
// Data memory model answering the core's read and write strobes
`timescale 1ns/1ps
`default_nettype none
module isd_mem_model (
	// Clock
	input wire logic aclk,
	// Data memory port
	input wire logic [11:0] dm_addr,
	input wire logic dm_rd_en,
	input wire logic dm_wr_en,
	input wire logic [7:0] dm_wdata,
	output logic [7:0] dm_rdata
);
	// Full 4K byte data space
	logic [7:0] mem [0:4095];
	// Last byte read, shown inverted while idle so stale data never matches
	logic [7:0] last_q = 8'h5a;
	// Read answers in the strobe cycle only
	always_comb begin
		dm_rdata = dm_rd_en ? mem[dm_addr] : ~last_q;
	end
	// Writes land at the edge
	always @(posedge aclk) begin
		if (dm_wr_en) mem[dm_addr] <= dm_wdata;
		if (dm_rd_en) last_q <= mem[dm_addr];
	end
endmodule // isd_mem_model
`default_nettype wire

// >>> dv/incr_skip_or_move_decode_test.sv
// Self-checking bench for the file-op decoder slice
`timescale 1ns/1ps
`default_nettype none
module incr_skip_or_move_decode_test import isd_pkg::*; ;
	// Driven inputs
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	// Observed outputs
	logic instr_ready, awready, wready, bvalid, arready, rvalid, dm_rd_en, dm_wr_en;
	logic [15:0] fetch_pc;
	logic [11:0] dm_addr;
	logic [7:0] dm_rdata, dm_wdata;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	// Expected state
	logic [7:0] exp_mem [0:4095];
	logic [7:0] e_acc = 8'h00;
	logic [1:0] e_fl = 2'h0;
	logic [3:0] e_bank = 4'h0;
	logic e_ext = 1'b0;
	logic [11:0] e_ptr [0:2] = '{12'h0, 12'h0, 12'h0};
	bit flush = 0;
	int bad_count = 0, comparisons = 0, words = 0;
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	isd_core isd_core_i (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .fetch_pc(fetch_pc), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en),
		.dm_rdata(dm_rdata), .dm_wr_en(dm_wr_en), .dm_wdata(dm_wdata), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	isd_mem_model isd_mem_model_i (.aclk(aclk), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en), .dm_wr_en(dm_wr_en),
		.dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// A wait ran out of cycles
	task automatic tmo();
		bad_count++;
		tally_and_finish();
	endtask
	// Wait until the core is back in decode
	task automatic idle();
		int n;
		// Step off the take edge so the phase update is visible
		#1;
		for (n = 0; n < 64 && !instr_ready; n++) begin
			@(posedge aclk);
			#1;
		end
		if (n == 64) tmo();
	endtask
	// Offer one program word and hold it until taken
	task automatic issue(input logic [15:0] w);
		int n;
		logic t;
		@(posedge aclk);
		instr_valid <= 1'b1;
		instr_word <= w;
		for (n = 0; n < 64; n++) begin
			#1;
			t = instr_ready;
			@(posedge aclk);
			if (t) break;
		end
		instr_valid <= 1'b0;
		words++;
		if (n == 64) tmo();
	endtask
	// Register write, address and data offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tw, tb;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= a;
		wdata <= d;
		for (n = 0; n < 64; n++) begin
			#1;
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) break;
		end
		bready <= 1'b0;
		if (n == 64) tmo();
	endtask
	// Register read
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tr;
		@(posedge aclk);
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= a;
		for (n = 0; n < 64; n++) begin
			#1;
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (n == 64) tmo();
	endtask
	// Read a register and compare data
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	// Data address formed from bank bit and file field
	function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f);
		if (a) return {e_bank, f};
		if (e_ext && f <= IDX_MAX) return e_ptr[IDX_PTR] + {4'h0, f};
		return {(f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f};
	endfunction
	// Run one instruction and predict its effect
	task automatic exec(input logic [15:0] w, input logic [15:0] w2, input bit two);
		logic [11:0] ea;
		logic [7:0] r;
		bit dst, fl;
		issue(w);
		if (two) issue(w2);
		ea = eaddr(w[8], w[7:0]);
		r = exp_mem[ea] + 8'h01;
		dst = 0;
		fl = 0;
		if (flush) flush = 0;
		else if (w[15:10] == PFX_INC_SKZ) begin
			dst = 1;
			flush = (r == 8'h00);
		end else if (w[15:10] == PFX_INC_SKNZ) begin
			dst = 1;
			flush = (r != 8'h00);
		end else if (w[15:10] == PFX_OR_FILE || w[15:10] == PFX_MOVE_FILE_VALUE) begin
			r = exp_mem[ea] | ((w[15:10] == PFX_OR_FILE) ? e_acc : 8'h00);
			dst = 1;
			fl = 1;
		end else if (w[15:8] == PFX_OR_LIT) begin
			e_acc = e_acc | w[7:0];
			r = e_acc;
			fl = 1;
		end else if (w[15:12] == PFX_MOVE_FILE_TO_FILE) exp_mem[w2[11:0]] = exp_mem[w[11:0]];
		else if (w[15:6] == PFX_LDPTR) e_ptr[w[5:4]] = {w[3:0], w2[7:0]};
		if (dst && w[9]) exp_mem[ea] = r;
		else if (dst) e_acc = r;
		if (fl) e_fl = {r[7], r == 8'h00};
		idle();
		rd_chk(REG_ACC, {24'h0, e_acc});
		rd_chk(REG_FLAGS, {30'h0, e_fl});
	endtask
	// Main sequence
	initial begin
		int i, k;
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] w, w2;
		void'($urandom(37630));
		for (i = 0; i < 4096; i++) begin
			exp_mem[i] = ($urandom % 4 == 0) ? 8'hff : 8'($urandom);
			isd_mem_model_i.mem[i] = exp_mem[i];
		end
		exp_mem[16] = 8'hff;
		isd_mem_model_i.mem[16] = 8'hff;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'h0);
		axr(8'h20, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axw(8'h24, 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		axw(REG_PC, 32'h5, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		for (k = 0; k < 2; k++) begin
			e_ext = k[0];
			e_bank = 4'($urandom);
			e_ptr[IDX_PTR] = 12'($urandom);
			axw(REG_CTRL, {31'h0, e_ext}, r);
			axw(REG_BANK, {28'h0, e_bank}, r);
			axw(REG_PTR2, {20'h0, e_ptr[IDX_PTR]}, r);
			if (k == 0) begin
				exec({PFX_INC_SKZ, 2'b10, 8'h10}, 16'h0, 0);
				exec({PFX_MOVE_FILE_TO_FILE, 12'h000}, {PFX_SECOND, 12'hfff}, 1);
				exec({PFX_MOVE_FILE_TO_FILE, 12'hfff}, {PFX_SECOND, 12'h000}, 1);
				exec({PFX_INC_SKNZ, 2'b10, 8'h10}, 16'h0, 0);
				exec({PFX_JUMP_FAR, 8'h00}, {PFX_OR_LIT, 8'h5a}, 1);
			end
			for (i = 0; i < 45; i++) begin
				w = 16'($urandom);
				w2 = 16'($urandom);
				case ($urandom % 7)
					0: w[15:10] = PFX_INC_SKZ;
					1: w[15:10] = PFX_INC_SKNZ;
					2: w[15:10] = PFX_OR_FILE;
					3: w[15:10] = PFX_MOVE_FILE_VALUE;
					4: w[15:8] = PFX_OR_LIT;
					5: begin
						w[15:12] = PFX_MOVE_FILE_TO_FILE;
						w2[15:12] = PFX_SECOND;
					end
					default: begin
						w[15:4] = {PFX_LDPTR, 2'($urandom % 3)};
						w2[15:8] = 8'hf0;
					end
				endcase
				exec(w, w2, w[15:12] == PFX_MOVE_FILE_TO_FILE || w[15:6] == PFX_LDPTR);
			end
		end
		rd_chk(REG_PC, {16'h0, 16'(words)});
		for (i = 0; i < 3; i++) rd_chk(8'(REG_PTR0 + 4 * i), {20'h0, e_ptr[i]});
		for (i = 0; i < 4096; i++) chk({24'h0, isd_mem_model_i.mem[i]}, {24'h0, exp_mem[i]});
		tally_and_finish();
	end
endmodule // incr_skip_or_move_decode_test
`default_nettype wire
